/* verilog/dsw_pkg.sv */
// Purpose: Shared constants and types of the deep-sleep wake controller
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes: Counts of the low-frequency tick are in 32 KHz periods
package dsw_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] DSW_A_CTRL = 8'h00;
    localparam logic [7:0] DSW_A_WAKE_EN = 8'h04;
    localparam logic [7:0] DSW_A_TIMEOUT = 8'h08;
    localparam logic [7:0] DSW_A_WAKE_LAT = 8'h0C;
    localparam logic [7:0] DSW_A_CLK_EN = 8'h10;
    localparam logic [7:0] DSW_A_PERIPH_PWR = 8'h14;
    localparam logic [7:0] DSW_A_BUS_PWR = 8'h18;
    localparam logic [7:0] DSW_A_PAD_PWR = 8'h1C;
    localparam logic [7:0] DSW_A_STATUS = 8'h20;
    localparam logic [7:0] DSW_A_CMD = 8'h24;
    localparam logic [7:0] DSW_A_ASSOC = 8'h28;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int DSW_CTRL_RETAIN = 0;
    localparam int DSW_CTRL_IND_EN = 1;
    localparam int DSW_CTRL_ASSOC_EN = 2;
    localparam int DSW_WE_POL = 4;
    localparam int DSW_WE_SEL_LSB = 5;
    localparam int DSW_CMD_LVL_LSB = 2;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] DSW_RST_WAKE_LAT = 16'h0010;
    localparam logic [31:0] DSW_RST_TIMEOUT = 32'h0000_8000;
    localparam logic [15:0] DSW_RST_PERIOD = 16'h8000;
    localparam logic [15:0] DSW_RST_AWAKE = 16'h0100;

    // ==========================================================
    // Clock figures
    // ==========================================================
    localparam int DSW_SYS_CLK_HZ = 100_000_000;
    localparam int DSW_LF_CLK_HZ = 32_768;

    // Power states, binary coded
    typedef enum logic [2:0] {
        DSW_ST_ACTIVE = 3'b000,
        DSW_ST_STANDBY = 3'b001,
        DSW_ST_SLEEP = 3'b010,
        DSW_ST_SHUTDOWN = 3'b011,
        DSW_ST_WAKE = 3'b100
    } dsw_state_t;

    // Software state commands
    localparam logic [1:0] DSW_CMD_ACTIVE = 2'h0;
    localparam logic [1:0] DSW_CMD_STANDBY = 2'h1;
    localparam logic [1:0] DSW_CMD_SLEEP = 2'h2;
    localparam logic [1:0] DSW_CMD_SHUTDOWN = 2'h3;

endpackage

/* verilog/dsw_ctrl.sv */
// Purpose: Power-state sequencer and deep-sleep wake controller
// Assumes: Inputs other than ext_reset_n_in and power_ok_input_in synchronous to sys_clk_in; lf_clk_in is sampled
// Notes: External reset and power-ok act without the clock
//
// Summary of operation
// - Hardware sequences Active, Standby, Sleep, Shutdown states
// - Sleep manager decides which subsystems run
// - Always-on logic steps on 32 KHz in sleep
// - Sleep keeps timer; RAM retention selectable
// - Wake after programmed timeout count elapses
// - Wake on selected GPIO at programmed polarity
// - Wake on real-time-clock timeout
// - Wake on watchdog interrupt timeout
// - Wake completes in hardware, no software
// - Associated standby wakes periodically, then returns
// - Peripheral clocks gated after reset until enabled
// - Separate power gates for peripherals, buses, pads
// - Software switches between Active performance levels
// - Wake latency set by software
// - External reset asynchronous, active low
// - Power-ok low forces internal reset low
// - Power-ok output high once both supplies valid
// - Sleep indication low in deep sleep
`timescale 1ns/1ns
module dsw_ctrl
    import dsw_pkg::*;
#(
    parameter int NPERIPH = 16,
    parameter int NBUS = 4,
    parameter int NPAD = 8,
    parameter int NSUB = 4,
    parameter int NGPIO = 8
)
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic ext_reset_n_in,
    input wire logic power_ok_input_in,
    input wire logic always_on_battery_supply_ok_in,
    input wire logic switched_cap_output_ok_in,
    input wire logic lf_clk_in,
    input wire logic [NGPIO-1:0] gpio_in,
    input wire logic rtc_timeout_in,
    input wire logic wdt_irq_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    output logic [NPERIPH-1:0] periph_clk_en_out,
    output logic [NPERIPH-1:0] periph_pwr_en_out,
    output logic [NBUS-1:0] bus_pwr_en_out,
    output logic [NPAD-1:0] pad_pwr_en_out,
    output logic [NSUB-1:0] subsys_run_out,
    output logic [1:0] active_level_out,
    output logic lf_clk_sel_out,
    output logic ram_retain_out,
    output logic sleep_indication_out,
    output logic power_ok_output_out,
    output logic internal_reset_n_out,
    output logic [2:0] state_out
);

    localparam int SELW = (NGPIO > 1) ? $clog2(NGPIO) : 1;

    // ==========================================================
    // State record
    // ==========================================================
    typedef struct packed {
        dsw_state_t state;
        logic retain;
        logic ind_en;
        logic assoc_en;
        logic [3:0] wake_en;
        logic gpio_pol;
        logic [SELW-1:0] gpio_sel;
        logic [31:0] timeout;
        logic [15:0] wake_lat;
        logic [15:0] period;
        logic [15:0] awake;
        logic [NPERIPH-1:0] clk_en;
        logic [NPERIPH-1:0] pperiph;
        logic [NBUS-1:0] pbus;
        logic [NPAD-1:0] ppad;
        logic [1:0] level;
        logic auto_wake;
        logic [31:0] cnt;
        logic [4:0] cause;
        logic lf_prev;
        logic [31:0] rd_data;
        logic [NPERIPH-1:0] o_clk;
        logic [NPERIPH-1:0] o_pper;
        logic [NBUS-1:0] o_pbus;
        logic [NPAD-1:0] o_ppad;
        logic [NSUB-1:0] o_sub;
        logic o_lf;
        logic o_ret;
        logic o_ind;
        logic o_pok;
    } dsw_regs_t;

    dsw_regs_t q; // Registered state
    dsw_regs_t d; // Next state
    logic [1:0] rst_sync_q; // Reset release synchroniser
    logic arst_n; // Combined asynchronous reset
    logic srst; // Internal synchronous reset
    logic lf_tick; // Rising edge of the low-frequency clock
    logic deep; // Next state is a deep-sleep state
    logic w_tmo, w_gpio, w_rtc, w_wdt, w_assoc;
    logic wake_any;

    // ==========================================================
    // Reset handling
    // ==========================================================
    // asynchronous assert
    assign arst_n = ext_reset_n_in & power_ok_input_in;

    // synchronised release; a raw release could split the state
    // record across two clock edges
    always_ff @(posedge sys_clk_in or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign srst = reset_in | ~rst_sync_q[1];
    assign internal_reset_n_out = rst_sync_q[1];

    // ==========================================================
    // Wake sources
    // ==========================================================
    // Low-frequency clock is sampled, so the sleep timer steps once
    // per 32 KHz period
    assign lf_tick = lf_clk_in & ~q.lf_prev;

    // timer wake, counted only in Sleep
    assign w_tmo = q.wake_en[0] & (q.state == DSW_ST_SLEEP) & lf_tick
        & (q.cnt + 32'h0000_0001 >= q.timeout);
    assign w_gpio = q.wake_en[1] & (gpio_in[q.gpio_sel] == q.gpio_pol);
    assign w_rtc = q.wake_en[2] & rtc_timeout_in;
    assign w_wdt = q.wake_en[3] & wdt_irq_in;
    assign w_assoc = q.assoc_en & (q.state == DSW_ST_STANDBY) & lf_tick
        & (q.cnt + 32'h0000_0001 >= {16'h0000, q.period});
    assign wake_any = w_tmo | w_gpio | w_rtc | w_wdt | w_assoc;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb
    begin
        d = q;
        d.lf_prev = lf_clk_in;
        d.rd_data = 32'h0000_0000;

        // Register writes
        if (wr_in)
        begin
            case (addr_in)
                DSW_A_CTRL:
                begin
                    d.retain = wr_data_in[DSW_CTRL_RETAIN];
                    d.ind_en = wr_data_in[DSW_CTRL_IND_EN];
                    d.assoc_en = wr_data_in[DSW_CTRL_ASSOC_EN];
                end
                DSW_A_WAKE_EN:
                begin
                    d.wake_en = wr_data_in[3:0];
                    d.gpio_pol = wr_data_in[DSW_WE_POL];
                    d.gpio_sel = wr_data_in[DSW_WE_SEL_LSB +: SELW];
                end
                DSW_A_TIMEOUT: d.timeout = wr_data_in;
                DSW_A_WAKE_LAT: d.wake_lat = wr_data_in[15:0];
                DSW_A_CLK_EN: d.clk_en = wr_data_in[NPERIPH-1:0];
                DSW_A_PERIPH_PWR: d.pperiph = wr_data_in[NPERIPH-1:0];
                DSW_A_BUS_PWR: d.pbus = wr_data_in[NBUS-1:0];
                DSW_A_PAD_PWR: d.ppad = wr_data_in[NPAD-1:0];
                DSW_A_ASSOC:
                begin
                    d.period = wr_data_in[15:0];
                    d.awake = wr_data_in[31:16];
                end
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (rd_in)
        begin
            case (addr_in)
                DSW_A_CTRL: d.rd_data = {29'h0, q.assoc_en, q.ind_en, q.retain};
                DSW_A_WAKE_EN: d.rd_data = 32'({q.gpio_sel, q.gpio_pol, q.wake_en});
                DSW_A_TIMEOUT: d.rd_data = q.timeout;
                DSW_A_WAKE_LAT: d.rd_data = {16'h0000, q.wake_lat};
                DSW_A_CLK_EN: d.rd_data = 32'(q.clk_en);
                DSW_A_PERIPH_PWR: d.rd_data = 32'(q.pperiph);
                DSW_A_BUS_PWR: d.rd_data = 32'(q.pbus);
                DSW_A_PAD_PWR: d.rd_data = 32'(q.ppad);
                DSW_A_STATUS: d.rd_data = {20'h0, q.o_pok, q.cause, q.level,
                    q.auto_wake, q.state};
                DSW_A_CMD: d.rd_data = {28'h0, q.level, 2'b00};
                DSW_A_ASSOC: d.rd_data = {q.awake, q.period};
                // Unmapped addresses read as zero
                default: d.rd_data = 32'h0000_0000;
            endcase
        end

        case (q.state)
            DSW_ST_ACTIVE:
            begin
                // Awake window counts only after a periodic wake
                d.cnt = q.auto_wake ? q.cnt + 32'h0000_0001 : q.cnt;
                // return to standby after the awake window
                if (q.auto_wake && q.cnt >= {16'h0000, q.awake})
                begin
                    d.state = DSW_ST_STANDBY;
                    d.cnt = 32'h0000_0000;
                    d.auto_wake = 1'b0;
                end
                if (wr_in && addr_in == DSW_A_CMD)
                begin
                    d.level = wr_data_in[DSW_CMD_LVL_LSB +: 2];
                    d.auto_wake = 1'b0;
                    d.cnt = 32'h0000_0000;
                    case (wr_data_in[1:0])
                        DSW_CMD_STANDBY: d.state = DSW_ST_STANDBY;
                        DSW_CMD_SLEEP: d.state = DSW_ST_SLEEP;
                        DSW_CMD_SHUTDOWN: d.state = DSW_ST_SHUTDOWN;
                        default: d.state = DSW_ST_ACTIVE;
                    endcase
                    if (wr_data_in[1:0] != DSW_CMD_ACTIVE)
                        d.cause = 5'h00;
                end
            end
            DSW_ST_STANDBY, DSW_ST_SLEEP, DSW_ST_SHUTDOWN:
            begin
                // sleep timer steps on the 32 KHz tick only
                if (lf_tick && q.state != DSW_ST_SHUTDOWN)
                    d.cnt = q.cnt + 32'h0000_0001;
                if (wake_any)
                begin
                    d.state = DSW_ST_WAKE;
                    d.cnt = 32'h0000_0000;
                    d.auto_wake = w_assoc & ~(w_tmo | w_gpio | w_rtc | w_wdt);
                    d.cause = {w_assoc, w_wdt, w_rtc, w_gpio, w_tmo};
                end
            end
            DSW_ST_WAKE:
            begin
                d.cnt = q.cnt + 32'h0000_0001;
                if (q.cnt >= {16'h0000, q.wake_lat})
                begin
                    d.state = DSW_ST_ACTIVE;
                    d.cnt = 32'h0000_0000;
                end
            end
            default: d.state = DSW_ST_ACTIVE;
        endcase

        // Outputs follow the next state so they leave from flops
        deep = (d.state == DSW_ST_SLEEP) || (d.state == DSW_ST_SHUTDOWN);
        // clocks gated unless enabled and active
        d.o_clk = (d.state == DSW_ST_ACTIVE) ? d.clk_en : '0;
        // power gates drop in every low state
        d.o_pper = (d.state == DSW_ST_ACTIVE) ? d.pperiph : '0;
        d.o_pbus = (d.state == DSW_ST_ACTIVE) ? d.pbus : '0;
        d.o_ppad = (d.state == DSW_ST_ACTIVE) ? d.ppad : '0;
        // sleep manager owns subsystem run state
        d.o_sub = (d.state == DSW_ST_ACTIVE) ? '1 : '0;
        // low-frequency clock for the always-on domain
        d.o_lf = deep;
        // retention kept unless shutdown, or sleep with retention not selected
        d.o_ret = !(d.state == DSW_ST_SHUTDOWN)
            && !(d.state == DSW_ST_SLEEP && !d.retain);
        // low while in deep sleep, when enabled
        d.o_ind = !(deep && d.ind_en);
        d.o_pok = always_on_battery_supply_ok_in & switched_cap_output_ok_in;
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Synchronous reset; power-ok and external reset reach it through
    // the synchroniser, so reset_in is the only port value that enters this reset branch
    always_ff @(posedge sys_clk_in)
    begin
        if (srst)
        begin
            q <= '0;
            q.state <= DSW_ST_ACTIVE;
            q.timeout <= DSW_RST_TIMEOUT;
            q.wake_lat <= DSW_RST_WAKE_LAT;
            q.period <= DSW_RST_PERIOD;
            q.awake <= DSW_RST_AWAKE;
            q.retain <= 1'b1;
            q.o_ret <= 1'b1;
            q.o_ind <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign rd_data_out = q.rd_data;
    assign periph_clk_en_out = q.o_clk;
    assign periph_pwr_en_out = q.o_pper;
    assign bus_pwr_en_out = q.o_pbus;
    assign pad_pwr_en_out = q.o_ppad;
    assign subsys_run_out = q.o_sub;
    assign active_level_out = q.level;
    assign lf_clk_sel_out = q.o_lf;
    assign ram_retain_out = q.o_ret;
    assign sleep_indication_out = q.o_ind;
    assign power_ok_output_out = q.o_pok;
    assign state_out = q.state;

endmodule // dsw_ctrl

/* testbench/dsw_ctrl_monitor.sv */
// Purpose: Port checker for the deep-sleep wake controller
// Assumes: Bound to dsw_ctrl, one clock domain
// Notes: Cycle figures follow the hand-over timing of the design
`timescale 1ns/1ns
module dsw_ctrl_monitor
    import dsw_pkg::*;
#(
    parameter int NPERIPH = 16,
    parameter int NSUB = 4
)
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic ext_reset_n_in,
    input wire logic power_ok_input_in,
    input wire logic always_on_battery_supply_ok_in,
    input wire logic switched_cap_output_ok_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic [NPERIPH-1:0] periph_clk_en_out,
    input wire logic [NSUB-1:0] subsys_run_out,
    input wire logic lf_clk_sel_out,
    input wire logic ram_retain_out,
    input wire logic sleep_indication_out,
    input wire logic power_ok_output_out,
    input wire logic internal_reset_n_out,
    input wire logic [2:0] state_out
);
    // ==========================================================
    // Helper logic
    // ==========================================================
    // Previous edge was out of reset, so outputs come from live state
    logic live_q;
    logic up;
    always_ff @(posedge sys_clk_in)
    begin
        live_q <= !reset_in && internal_reset_n_out;
    end
    assign up = live_q && internal_reset_n_out;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // ==========================================================
    // Sequences
    // ==========================================================
    // Software asks for Sleep while Active
    sequence s_sleep_cmd;
        up && state_out == DSW_ST_ACTIVE && wr_in && addr_in == DSW_A_CMD
            && wr_data_in[1:0] == DSW_CMD_SLEEP;
    endsequence
    // Both reset sources released for three edges
    sequence s_release;
        (ext_reset_n_in && power_ok_input_in) [*3];
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    AST_EXT_RST: assert property (!ext_reset_n_in |-> !internal_reset_n_out)
        else $error("internal reset high while external reset low");
    AST_POK_RST: assert property (!power_ok_input_in |-> !internal_reset_n_out)
        else $error("internal reset high while power ok input low");
    AST_RST_SYNC: assert property (s_release |-> internal_reset_n_out)
        else $error("internal reset not released two edges after sources");
    AST_PWR_OK: assert property (up |=> (!internal_reset_n_out
        || power_ok_output_out == $past(always_on_battery_supply_ok_in
        && switched_cap_output_ok_in))) else $error("power ok output wrong");
    AST_RST_GATES: assert property ($rose(internal_reset_n_out) |->
        periph_clk_en_out == '0 && state_out == DSW_ST_ACTIVE)
        else $error("clock gates open after reset");
    AST_SLEEP_ENTRY: assert property (s_sleep_cmd |=> state_out == DSW_ST_SLEEP
        && lf_clk_sel_out && periph_clk_en_out == '0)
        else $error("sleep command not followed by sleep");
    AST_RUN_MAP: assert property (up |->
        subsys_run_out == {NSUB{state_out == DSW_ST_ACTIVE}})
        else $error("subsystem run map does not match state");
    AST_ACTIVE_IND: assert property (up && state_out == DSW_ST_ACTIVE |->
        sleep_indication_out && !lf_clk_sel_out) else $error("active outputs wrong");
    AST_SHUT_RAM: assert property (up && state_out == DSW_ST_SHUTDOWN |->
        !ram_retain_out && lf_clk_sel_out) else $error("shutdown keeps ram");
    AST_WAKE_FROM: assert property (up && $changed(state_out)
        && state_out == DSW_ST_WAKE |-> $past(state_out) inside {3'h1, 3'h2, 3'h3})
        else $error("wake entered from wrong state");
    AST_WAKE_TO: assert property (up && $past(state_out) == DSW_ST_WAKE
        && state_out != DSW_ST_WAKE |-> state_out == DSW_ST_ACTIVE)
        else $error("wake left to wrong state");
endmodule // dsw_ctrl_monitor

bind dsw_ctrl dsw_ctrl_monitor #(.NPERIPH(NPERIPH), .NSUB(NSUB)) u_mon (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .ext_reset_n_in(ext_reset_n_in),
    .power_ok_input_in(power_ok_input_in),
    .always_on_battery_supply_ok_in(always_on_battery_supply_ok_in),
    .switched_cap_output_ok_in(switched_cap_output_ok_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .periph_clk_en_out(periph_clk_en_out),
    .subsys_run_out(subsys_run_out), .lf_clk_sel_out(lf_clk_sel_out),
    .ram_retain_out(ram_retain_out), .sleep_indication_out(sleep_indication_out),
    .power_ok_output_out(power_ok_output_out),
    .internal_reset_n_out(internal_reset_n_out), .state_out(state_out));

/* testbench/dsw_supervisor_model.sv */
// Purpose: System supervisor and slow clock source beside the controller
// Assumes: Brownout request comes from the bench
// Notes: Ramp offsets keep supply rises away from system clock edges
`timescale 1ns/1ns
module dsw_supervisor_model
(
    input wire logic brownout_in,
    output logic power_ok_input_out,
    output logic aon_ok_out,
    output logic scap_ok_out,
    output logic lf_clk_out
);
    // ==========================================================
    // Slow clock, free running near 32 KHz
    // ==========================================================
    initial lf_clk_out = 1'b0;
    always #15258 lf_clk_out = ~lf_clk_out;

    // Supplies ramp one after another; drop together on brownout
    initial
    begin
        power_ok_input_out = 1'b0;
        aon_ok_out = 1'b0;
        scap_ok_out = 1'b0;
        forever
        begin
            wait (brownout_in === 1'b0);
            #42 aon_ok_out = 1'b1;
            #44 scap_ok_out = 1'b1;
            #62 power_ok_input_out = 1'b1;
            wait (brownout_in === 1'b1);
            power_ok_input_out = 1'b0;
            aon_ok_out = 1'b0;
            scap_ok_out = 1'b0;
        end
    end
endmodule // dsw_supervisor_model

/* testbench/deep_sleep_wake_controller_test.sv */
// Purpose: Self-checking bench of the deep-sleep wake controller
// Assumes: Register port answers reads one cycle later
// Notes: Reads are scored by a queue; port checks are made at the falling edge
`timescale 1ns/1ns
module deep_sleep_wake_controller_test;
    import dsw_pkg::*;
    logic sys_clk_in = 1'b0, reset_in = 1'b1, ext_reset_n_in = 1'b1, brown = 1'b0;
    logic rtc_timeout_in = 1'b0, wdt_irq_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
    logic [7:0] gpio_in = 8'h00, addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0, rd_data_out, v, m;
    logic pok, aon, scap, lf_clk, lf_sel, ram_ret, sleep_ind, pok_out, irst_n;
    logic [15:0] pclk, ppwr;
    logic [3:0] bpwr, subs;
    logic [7:0] padp;
    logic [1:0] lvl;
    logic [2:0] state_out;
    logic [31:0] exp_q[$], msk_q[$];
    int errors = 0, total_checks = 0, seed, n;

    always #5 sys_clk_in = ~sys_clk_in;

    dsw_supervisor_model sup (.brownout_in(brown), .power_ok_input_out(pok),
        .aon_ok_out(aon), .scap_ok_out(scap), .lf_clk_out(lf_clk));
    dsw_ctrl uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .ext_reset_n_in(ext_reset_n_in), .power_ok_input_in(pok),
        .always_on_battery_supply_ok_in(aon), .switched_cap_output_ok_in(scap),
        .lf_clk_in(lf_clk), .gpio_in(gpio_in), .rtc_timeout_in(rtc_timeout_in),
        .wdt_irq_in(wdt_irq_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .periph_clk_en_out(pclk), .periph_pwr_en_out(ppwr), .bus_pwr_en_out(bpwr),
        .pad_pwr_en_out(padp), .subsys_run_out(subs), .active_level_out(lvl),
        .lf_clk_sel_out(lf_sel), .ram_retain_out(ram_ret),
        .sleep_indication_out(sleep_ind), .power_ok_output_out(pok_out),
        .internal_reset_n_out(irst_n), .state_out(state_out));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask
    // Read notes the expectation; the scoring process compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(mk);
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
    endtask
    // Bounded wait on state; n returns the falling edges spent
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (state_out !== s && n < 20000)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        cmp(32'(state_out), 32'(s));
    endtask
    task automatic wait_up();
        n = 0;
        while (irst_n !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        // A reset that never lifts is a failure
        if (irst_n !== 1'b1)
            errors++;
        @(posedge sys_clk_in);
    endtask
    task automatic stop_test();
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Read data stand one cycle after the strobe
    always @(posedge sys_clk_in)
    begin
        if (rd_d)
        begin
            m = msk_q.pop_front();
            cmp(rd_data_out & m, exp_q.pop_front() & m);
        end
        rd_d <= rd_in;
    end

    // Hang guard, well past the longest expected run
    initial
    begin
        #800000;
        errors++;
        stop_test();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        seed = 92495;
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        wait_up();
        rd(DSW_A_CTRL, 32'h1, 32'h7);
        rd(DSW_A_TIMEOUT, 32'h8000, 32'hFFFF_FFFF);
        rd(DSW_A_WAKE_LAT, 32'h10, 32'hFFFF);
        rd(DSW_A_ASSOC, 32'h0100_8000, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
        cmp(32'(pclk), 32'h0);
        // Random gate patterns reach the ports; clock enables read back
        v = $random(seed);
        wr(DSW_A_CLK_EN, 32'(v[15:0]));
        wr(DSW_A_PERIPH_PWR, 32'(v[31:16]));
        wr(DSW_A_BUS_PWR, 32'(v[3:0]));
        wr(DSW_A_PAD_PWR, 32'(v[11:4]));
        @(negedge sys_clk_in);
        cmp({pclk, ppwr}, {v[15:0], v[31:16]});
        cmp(32'({bpwr, padp}), 32'({v[3:0], v[11:4]}));
        rd(DSW_A_CLK_EN, 32'(v[15:0]), 32'hFFFF);
        for (int i = 0; i < 4; i++)
        begin
            wr(DSW_A_CMD, 32'(i << DSW_CMD_LVL_LSB));
            @(negedge sys_clk_in);
            cmp(32'(lvl), 32'(i));
        end
        // Each wake source in turn, indication on, no retention
        wr(DSW_A_WAKE_LAT, 32'h2);
        wr(DSW_A_TIMEOUT, 32'h4);
        wr(DSW_A_CTRL, 32'h2);
        for (int s = 0; s < 4; s++)
        begin
            v = (s == 0) ? 32'(DSW_ST_SLEEP) : (s == 1) ? 32'(DSW_ST_STANDBY)
                : 32'(DSW_ST_SHUTDOWN);
            wr(DSW_A_WAKE_EN, 32'h70 | (32'h1 << s));
            gpio_in <= 8'($random(seed)) & 8'hF7;
            wr(DSW_A_CMD, v);
            @(negedge sys_clk_in);
            cmp(32'(state_out), v);
            // Standby is not deep sleep: indication high, RAM kept, fast clock
            cmp(32'({sleep_ind, subs}), (s == 1) ? 32'h10 : 32'h0);
            cmp(32'({lf_sel, ram_ret}), (s == 1) ? 32'h1 : 32'h2);
            @(posedge sys_clk_in);
            // Disabled sources must not wake the timer case
            rtc_timeout_in <= (s == 0 || s == 2);
            wdt_irq_in <= (s == 0 || s == 3);
            gpio_in[3] <= (s == 1);
            if (s == 0)
            begin
                @(posedge sys_clk_in);
                rtc_timeout_in <= 1'b0;
                wdt_irq_in <= 1'b0;
            end
            wait_st(DSW_ST_WAKE);
            @(posedge sys_clk_in);
            rtc_timeout_in <= 1'b0;
            wdt_irq_in <= 1'b0;
            gpio_in[3] <= 1'b0;
            wait_st(DSW_ST_ACTIVE);
            cmp(n, 32'h3);
            cmp(32'(sleep_ind), 32'h1);
            rd(DSW_A_STATUS, (32'h1 << s) << 6, 32'h7C7);
        end
        // Associated standby wakes on its own and returns
        wr(DSW_A_ASSOC, 32'h0003_0004);
        wr(DSW_A_CTRL, 32'h5);
        wr(DSW_A_CMD, 32'(DSW_CMD_STANDBY));
        wait_st(DSW_ST_WAKE);
        wait_st(DSW_ST_ACTIVE);
        wait_st(DSW_ST_STANDBY);
        cmp(n, 32'h4);
        // External reset in mid-standby
        @(posedge sys_clk_in);
        ext_reset_n_in <= 1'b0;
        @(negedge sys_clk_in);
        cmp(32'(irst_n), 32'h0);
        @(posedge sys_clk_in);
        ext_reset_n_in <= 1'b1;
        wait_up();
        @(negedge sys_clk_in);
        cmp(32'({state_out, pclk}), 32'h0);
        // Brownout from the supervisor
        brown <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        cmp(32'({irst_n, pok_out}), 32'h0);
        brown <= 1'b0;
        wait_up();
        repeat (2) @(negedge sys_clk_in);
        cmp(32'(pok_out), 32'h1);
        stop_test();
    end
endmodule // deep_sleep_wake_controller_test
